// ===== shared/apd_pkg.sv
// constants and types for the audio pwm speaker driver
package apd_pkg;
	localparam int APD_CLK_HZ = 40_000_000;
	localparam int APD_RATE_HZ = 32_000;
	localparam int APD_FRAME_CYC = APD_CLK_HZ / APD_RATE_HZ;
	localparam int APD_CNT_W = 11;
	localparam int APD_MAG_W = 11;
	localparam int APD_ADDR_W = 8;

	// register indices; byte address is four times the index
	localparam logic [4:0] APD_IDX_STATUS = 5'h00;
	localparam logic [4:0] APD_IDX_EXTRA = 5'h08;
	localparam logic [4:0] APD_IDX_CTRL = 5'h09;
	localparam logic [4:0] APD_IDX_LOW = 5'h0a;
	localparam logic [4:0] APD_IDX_HIGH = 5'h0b;
	localparam logic [4:0] APD_IDX_DRIVE = 5'h13;

	localparam int APD_STATUS_FLAG_BIT = 2;
	localparam int APD_CTRL_EN_BIT = 0;
	localparam int APD_CTRL_GIE_BIT = 1;
	localparam int APD_DRIVE_LOW_BIT = 2;
	localparam int APD_DRIVE_HIGH_BIT = 3;
	localparam int APD_DRIVE_SUPPLY_BIT = 0;

	localparam logic [3:0] APD_DRIVE_RESET = 4'hc;
	localparam logic [3:0] APD_NIBBLE_RESET = 4'h0;
	localparam logic [11:0] APD_IRQ_VECTOR = 12'h008;

	typedef enum logic [1:0] {
		APD_MODE_8 = 2'b00,
		APD_MODE_10 = 2'b01,
		APD_MODE_12 = 2'b10
	} apd_mode_t;
endpackage

// ===== src/apd_top.sv
// audio pwm speaker driver with apb register slave
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module apd_top import apd_pkg::*; #(
	parameter int FRAME_CYC = APD_FRAME_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ten_bit_option,
	input wire logic twelve_bit_option,
	input wire logic halt_req,
	input wire logic supply_low_flag,
	output logic speaker_plus_pin,
	output logic speaker_plus_oe,
	output logic speaker_minus_pin,
	output logic speaker_minus_oe,
	output logic [1:0] drive_level,
	output logic irq_take,
	output logic [11:0] irq_vector
);
	localparam logic [APD_CNT_W-1:0] FRAME_LAST = APD_CNT_W'(FRAME_CYC - 1);

	logic rst_meta_q;
	logic rst_sync_n;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic flag_q;
	logic en_q;
	logic gie_q;
	logic halted_q;
	logic [3:0] extra_q;
	logic [3:0] low_q;
	logic [3:0] high_q;
	logic [3:0] drive_q;
	logic act_sign_q;
	logic [APD_MAG_W-1:0] act_mag_q;
	logic [APD_CNT_W-1:0] cnt_q;
	logic plus_q;
	logic minus_q;
	logic plus_oe_q;
	logic minus_oe_q;
	logic take_q;
	logic [11:0] vec_q;
	logic [1:0] drive_lvl_q;

	logic [4:0] idx;
	logic setup_ph;
	logic wr_fire;
	logic frame_end;
	logic mapped;
	apd_mode_t mode;
	logic [APD_MAG_W:0] buf_sample;
	logic wr_ok;
	logic pins_live;

	function automatic apd_mode_t decode_mode(input logic opt10,
		input logic opt12);
		if (opt12) begin
			return APD_MODE_12;
		end else if (opt10) begin
			return APD_MODE_10;
		end
		return APD_MODE_8;
	endfunction

	// returns {sign, magnitude} from high and low, plus extra in the 10 and 12 bit modes
	function automatic logic [APD_MAG_W:0] build_sample(input apd_mode_t m,
		input logic [3:0] hi, input logic [3:0] lo, input logic [3:0] ex);
		logic [11:0] raw;
		raw = 12'h000;
		unique case (m)
			APD_MODE_12: begin
				raw = {hi, lo, ex};
				return {raw[11], raw[10:0]};
			end
			APD_MODE_10: begin
				raw = {2'b00, hi, lo, ex[3:2]};
				return {raw[9], 2'b00, raw[8:0]};
			end
			default: begin
				raw = {4'h0, hi, lo};
				return {raw[7], 4'h0, raw[6:0]};
			end
		endcase
	endfunction

	// a completed write that lands on register want
	function automatic logic hit(input logic fire, input logic [4:0] at,
		input logic [4:0] want);
		return fire && (at == want);
	endfunction

	// only aligned addresses of the six registers answer
	function automatic logic in_map(input logic [APD_ADDR_W-1:0] a);
		logic [4:0] i;
		i = a[6:2];
		if (a[1:0] != 2'b00 || a[7] != 1'b0) begin
			return 1'b0;
		end
		return i == APD_IDX_STATUS || i == APD_IDX_EXTRA ||
			i == APD_IDX_CTRL || i == APD_IDX_LOW ||
			i == APD_IDX_HIGH || i == APD_IDX_DRIVE;
	endfunction

	// pin stays high for the first m clocks of the frame
	function automatic logic pulse_on(input logic [APD_CNT_W-1:0] c,
		input logic [APD_MAG_W-1:0] m);
		return c < m;
	endfunction

	// options are static fuses, read without synchronising
	// mode fixed by option pins
	assign mode = decode_mode(ten_bit_option, twelve_bit_option);
	assign buf_sample = build_sample(mode, high_q, low_q, extra_q);

	assign idx = paddr[6:2];
	assign setup_ph = psel & ~penable;
	assign wr_fire = psel & penable & pready_q & pwrite;
	assign frame_end = en_q && (cnt_q == FRAME_LAST);
	assign mapped = in_map(paddr);
	assign wr_ok = wr_fire & mapped;

	// pins float when halted or drive select is zero
	assign pins_live = ~halted_q & ~halt_req & (drive_q[3:2] != 2'b00);

	// reset asserts at once, releases through two flops

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// one wait state on every apb access
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
		end
	end

	// read data captured in the setup cycle; write-only nibbles read zero
	// cleared after the answer so data stands through the wait state and the pready cycle, no longer
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata_q <= 32'h0000_0000;
			if (!pwrite && mapped) begin
				unique case (idx)
					APD_IDX_STATUS: begin
						prdata_q[APD_STATUS_FLAG_BIT] <= flag_q;
					end
					APD_IDX_CTRL: begin
						prdata_q[APD_CTRL_EN_BIT] <= en_q;
						prdata_q[APD_CTRL_GIE_BIT] <= gie_q;
					end
					APD_IDX_DRIVE: begin
						prdata_q[3:0] <= {drive_q[3:2], supply_low_flag,
							drive_q[APD_DRIVE_SUPPLY_BIT]};
					end
					default: begin
						prdata_q <= 32'h0000_0000;
					end
				endcase
			end
		end else if (pready_q) begin
			prdata_q <= 32'h0000_0000;
		end
	end

	// frame end sets the flag, winning over a software write
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flag_q <= 1'b0;
		end else if (frame_end) begin
			flag_q <= 1'b1;
		end else if (hit(wr_ok, idx, APD_IDX_STATUS)) begin
			flag_q <= pwdata[APD_STATUS_FLAG_BIT];
		end
	end

	// halt clears enable, over any write
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			en_q <= 1'b0;
		end else if (halt_req) begin
			en_q <= 1'b0;
		end else if (hit(wr_ok, idx, APD_IDX_CTRL)) begin
			en_q <= pwdata[APD_CTRL_EN_BIT];
		end
	end

	// pins stay floating after halt until software enables again
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			halted_q <= 1'b0;
		end else if (halt_req) begin
			halted_q <= 1'b1;
		end else if (hit(wr_ok, idx, APD_IDX_CTRL) &&
			pwdata[APD_CTRL_EN_BIT]) begin
			// an enable write ends the float
			halted_q <= 1'b0;
		end
	end

	// entry clears global enable and wins over a write
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gie_q <= 1'b0;
		end else if (take_q) begin
			gie_q <= 1'b0;
		end else if (hit(wr_ok, idx, APD_IDX_CTRL)) begin
			gie_q <= pwdata[APD_CTRL_GIE_BIT];
		end
	end

	// take a pending flag one clock later
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			take_q <= 1'b0;
		end else begin
			take_q <= flag_q & gie_q & ~take_q;
		end
	end

	// entry vector held as a register output
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			vec_q <= APD_IRQ_VECTOR;
		end else begin
			vec_q <= APD_IRQ_VECTOR;
		end
	end

	// sample buffer nibbles
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			extra_q <= APD_NIBBLE_RESET;
			low_q <= APD_NIBBLE_RESET;
			high_q <= APD_NIBBLE_RESET;
		end else if (wr_ok) begin
			if (idx == APD_IDX_EXTRA) begin
				extra_q <= pwdata[3:0];
			end
			if (idx == APD_IDX_LOW) begin
				low_q <= pwdata[3:0];
			end
			if (idx == APD_IDX_HIGH) begin
				high_q <= pwdata[3:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			drive_q <= APD_DRIVE_RESET;
		end else if (hit(wr_ok, idx, APD_IDX_DRIVE)) begin
			// supply flag bit is live, not stored
			drive_q[3:2] <= pwdata[3:2];
			drive_q[APD_DRIVE_SUPPLY_BIT] <= pwdata[APD_DRIVE_SUPPLY_BIT];
		end
	end

	// load active stage at frame end; disabled it tracks the buffer
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			act_sign_q <= 1'b0;
			act_mag_q <= '0;
		end else if (frame_end || !en_q) begin
			act_sign_q <= buf_sample[APD_MAG_W];
			act_mag_q <= buf_sample[APD_MAG_W-1:0];
		end
	end

	// active stage holds its sample through each frame
	// held at zero while disabled so enable starts a clean frame
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cnt_q <= '0;
		end else if (!en_q || frame_end) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// pulse the pin chosen by the sign for magnitude clocks
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			plus_q <= 1'b0;
			minus_q <= 1'b0;
		end else begin
			plus_q <= en_q & ~act_sign_q & pulse_on(cnt_q, act_mag_q);
			minus_q <= en_q & act_sign_q & pulse_on(cnt_q, act_mag_q);
		end
	end

	// drive select and halt float the pins
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			plus_oe_q <= 1'b0;
			minus_oe_q <= 1'b0;
		end else begin
			plus_oe_q <= pins_live;
			minus_oe_q <= pins_live;
		end
	end

	// current level shown to the pad drivers
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			drive_lvl_q <= 2'b00;
		end else begin
			drive_lvl_q <= {drive_q[APD_DRIVE_HIGH_BIT],
				drive_q[APD_DRIVE_LOW_BIT]};
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign speaker_plus_pin = plus_q;
	assign speaker_minus_pin = minus_q;
	assign speaker_plus_oe = plus_oe_q;
	assign speaker_minus_oe = minus_oe_q;
	assign drive_level = drive_lvl_q;
	assign irq_take = take_q;
	assign irq_vector = vec_q;
endmodule

// ===== verification/apd_asserts.sv
// assertions on the pwm driver ports
`timescale 1ns/1ps
module apd_asserts #(parameter int FRAME_CYC = 1250) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic halt_req,
	input wire logic speaker_plus_pin,
	input wire logic speaker_plus_oe,
	input wire logic speaker_minus_pin,
	input wire logic speaker_minus_oe,
	input wire logic [1:0] drive_level,
	input wire logic irq_take,
	input wire logic [11:0] irq_vector
);
	logic act_q, seen_q;
	logic [15:0] gap_q;
	wire logic rise = (speaker_plus_pin | speaker_minus_pin) & ~act_q;
	wire logic ctl = psel & pwrite & (paddr == 8'h24);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// cycles since the last pulse start; a ctrl write restarts the frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= 1'h0;
			seen_q <= 1'h0;
			gap_q <= 16'h0000;
		end else begin
			act_q <= speaker_plus_pin | speaker_minus_pin;
			seen_q <= (seen_q | rise) & ~ctl & ~halt_req;
			gap_q <= rise ? 16'h0001 : gap_q + 16'h0001;
		end
	end
	AST_FRAME_RATE: assert property (
		rise && seen_q |-> gap_q % FRAME_CYC == 0) else $error("frame rate");
	AST_PINS_EXCL: assert property (
		!(speaker_plus_pin && speaker_minus_pin)) else $error("both pins");
	AST_HALT_FLOAT: assert property (
		halt_req |=> !speaker_plus_oe && !speaker_minus_oe) else $error("halt");
	AST_DRV_FLOAT: assert property (
		(drive_level == 2'h0) [*2] |-> !speaker_plus_oe && !speaker_minus_oe)
		else $error("float");
	AST_IRQ_VEC: assert property (
		irq_take |-> irq_vector == 12'h008) else $error("vector");
	AST_IRQ_ONCE: assert property (
		irq_take |=> !irq_take) else $error("irq pulse");
	AST_APB_WAIT: assert property (
		psel && $rose(penable) |-> !pready ##1 pready) else $error("wait");
	AST_ERR_PAIR: assert property (
		pslverr |-> pready && psel && penable) else $error("pslverr");
	cover property (irq_take);
	cover property (halt_req);
	cover property (rise && seen_q);
endmodule

bind apd_top apd_asserts #(.FRAME_CYC(FRAME_CYC)) apd_asserts_inst (.*);

// ===== verification/apd_speaker.sv
// speaker model measuring each drive pulse across the pin pair
`timescale 1ns/1ps
module apd_speaker (
	input wire logic clk_sys,
	input wire logic plus_pin,
	input wire logic plus_oe,
	input wire logic minus_pin,
	input wire logic minus_oe,
	output logic pulse_done = 1'h0,
	output logic pulse_neg = 1'h0,
	output logic [11:0] pulse_len = 12'h000
);
	logic [11:0] cnt_q = 12'h000;
	// a floating pin drives no current through the coil
	wire logic drv_p = plus_oe & plus_pin;
	wire logic drv_m = minus_oe & minus_pin;
	always @(posedge clk_sys) begin
		pulse_done <= 1'h0;
		if (drv_p | drv_m) begin
			cnt_q <= cnt_q + 12'h001;
			pulse_neg <= drv_m;
		end else if (cnt_q != 12'h000) begin
			pulse_done <= 1'h1;
			pulse_len <= cnt_q;
			cnt_q <= 12'h000;
		end
	end
endmodule

// ===== verification/audio_pwm_speaker_driver_bench.sv
// self-checking bench of the audio pwm speaker driver
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module audio_pwm_speaker_driver_bench import apd_pkg::*; ();
	logic clk_sys = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, halt_req = 1'h0, supply_low_flag = 1'h0, er;
	logic ten_bit_option = 1'h0, twelve_bit_option = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rv;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, speaker_plus_pin, speaker_plus_oe, sd, sn;
	wire logic speaker_minus_pin, speaker_minus_oe, irq_take;
	wire logic [1:0] drive_level;
	wire logic [11:0] irq_vector, sl;
	int n_fail = 0, checks_done = 0, cyc = 0, n = 0;
	// nibbles: ten, twelve, high, low, extra, sign; then length byte
	logic [31:0] tab [6] = '{32'h0015_f015, 32'h0093_f113, 32'h1007_d01f,
		32'h1080_4101, 32'h1182_5125, 32'h0102_0020};
	apd_top #(.FRAME_CYC(50)) apd_top_inst (.*);
	apd_speaker apd_speaker_inst (.clk_sys(clk_sys),
		.plus_pin(speaker_plus_pin), .plus_oe(speaker_plus_oe),
		.minus_pin(speaker_minus_pin), .minus_oe(speaker_minus_oe),
		.pulse_done(sd), .pulse_neg(sn), .pulse_len(sl));
	always #12.5 clk_sys = ~clk_sys;
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic apb(input logic w, input logic [4:0] i,
		input logic [3:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {1'h0, i, 2'h0};
		pwdata <= {28'h0, d};
		@(posedge clk_sys);
		penable <= 1'h1;
		// pready is sampled at the edge, before the design updates
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'h1);
		rv = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdc(input logic [4:0] i, input logic [32:0] x);
		apb(1'h0, i, 4'h0);
		`CHK({rv, er}, x)
	endtask
	task automatic pulse(input logic neg, input logic [7:0] len);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
		end while (sd !== 1'h1 && ++k < 200);
		`CHK({sn, sl}, {neg, 4'h0, len})
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
		rdc(APD_IDX_DRIVE, {32'h0000_000c, 1'h0});
		rdc(APD_IDX_LOW, {32'h0000_0000, 1'h0});
		rdc(5'h01, {32'h0000_0000, 1'h1});
		foreach (tab[k]) begin
			apb(1'h1, APD_IDX_CTRL, 4'h0);
			ten_bit_option <= tab[k][28];
			twelve_bit_option <= tab[k][24];
			apb(1'h1, APD_IDX_HIGH, tab[k][23:20]);
			apb(1'h1, APD_IDX_LOW, tab[k][19:16]);
			apb(1'h1, APD_IDX_EXTRA, tab[k][15:12]);
			apb(1'h1, APD_IDX_CTRL, 4'h1);
			pulse(tab[k][8], tab[k][7:0]);
			pulse(tab[k][8], tab[k][7:0]);
		end
		apb(1'h1, APD_IDX_HIGH, 4'h8);
		pulse(1'h1, 8'h20);
		apb(1'h1, APD_IDX_STATUS, 4'h0);
		apb(1'h1, APD_IDX_CTRL, 4'h3);
		do begin
			@(posedge clk_sys);
			#1;
		end while (irq_take !== 1'h1 && ++n < 200);
		`CHK(irq_take, 1'h1)
		rdc(APD_IDX_STATUS, {32'h0000_0004, 1'h0});
		rdc(APD_IDX_CTRL, {32'h0000_0001, 1'h0});
		apb(1'h1, APD_IDX_CTRL, 4'h0);
		repeat (60) begin
			@(posedge clk_sys);
			#1;
			`CHK({speaker_plus_pin, speaker_minus_pin}, 2'h0)
		end
		for (int d = 0; d < 4; d++) begin
			supply_low_flag <= d[0];
			apb(1'h1, APD_IDX_DRIVE, {d[1:0], 2'h1});
			rdc(APD_IDX_DRIVE, {28'h0, d[1:0], d[0], 2'h2});
			`CHK({drive_level, speaker_plus_oe}, {d[1:0], d != 0})
		end
		apb(1'h1, APD_IDX_CTRL, 4'h1);
		halt_req <= 1'h1;
		@(posedge clk_sys);
		halt_req <= 1'h0;
		@(posedge clk_sys);
		#1;
		`CHK({speaker_plus_oe, speaker_minus_oe}, 2'h0)
		rdc(APD_IDX_CTRL, {32'h0000_0000, 1'h0});
		apb(1'h1, APD_IDX_CTRL, 4'h1);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK({speaker_plus_oe, speaker_minus_oe}, 2'h3)
		end_of_test();
	end
endmodule
